// *** design/charge_safety_supervisor.sv ***
// Charge safety supervisor: safety timers, source checks, status pin
// Operation
// - Long timer at charge; any write disables
// - Long timer disabled starts short timer
// - Kick bit restarts short timer, self-clears
// - Short expiry: defaults, long timer, resume
// - Long expiry: stop, fault code, pulse
// - Timer fault cleared by reset; other faults read-gated
// - Power-up uses programmed or default values
// - Long mode, battery high: high impedance
// - Input limit from pin or register
// - Thermal shutdown: converter off, timers except pulse frozen
// - Sleep: reverse switch and converter off
// - Source test 30ms, reject, retry later
// - Input sag: reduce current, flag set
// - Input over-voltage stops, auto resumes
// - Battery over-voltage stops, auto resumes
// - Termination check with detect sink
// - Power-up battery detect 32ms window
// - Low battery: short-circuit charge mode
// - Status pin low while charging, pulses
// - Fault pulse for every charge fault
// - New cycle on recharge, power-on, host
`default_nettype none
`include "chg_sup_cfg.svh"
module charge_safety_supervisor #(
  parameter int P_LONG_TICKS   = `CS_LONG_MIN * `CS_S_PER_MIN * `CS_US_PER_S / `CS_TICK_US,
  parameter int P_SHORT_TICKS  = `CS_SHORT_S * `CS_US_PER_S / `CS_TICK_US,
  parameter int P_SRC_TICKS    = `CS_SRC_MS * `CS_US_PER_MS / `CS_TICK_US,
  parameter int P_BATDET_TICKS = `CS_BATDET_MS * `CS_US_PER_MS / `CS_TICK_US,
  parameter int P_DETECT_TICKS = `CS_DETECT_MS * `CS_US_PER_MS / `CS_TICK_US,
  parameter int P_RETRY_TICKS  = `CS_RETRY_MS * `CS_US_PER_MS / `CS_TICK_US,
  parameter bit P_HAS_PORT_SEL = 1'b1,
  parameter bit P_HAS_BATDET   = 1'b1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_vbus_por,
  input  wire logic             i_vbus_min,
  input  wire logic             i_vbus_sleep,
  input  wire logic             i_vbus_ovp,
  input  wire logic             i_vbus_sag,
  input  wire logic             i_bat_ovp,
  input  wire logic             i_bat_low,
  input  wire logic             i_bat_short,
  input  wire logic             i_bat_rch,
  input  wire logic             i_term_cur,
  input  wire logic             i_therm_shdn,
  input  wire logic             i_port_sel,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic [7:0]       i_reg_wdata,
  output logic      [7:0]       o_reg_rdata,
  output chg_sup_pkg::lim_code_t o_ilim_code,
  output logic                  o_conv_en,
  output logic                  o_rev_sw_en,
  output logic                  o_test_sink,
  output logic                  o_detect_sink,
  output logic                  o_short_chg,
  output logic                  o_cur_reduce,
  output logic                  o_hiz,
  output logic                  o_use_defaults,
  output logic                  o_stat_out,
  output logic                  o_stat_oe
);
  import chg_sup_pkg::*;

  localparam int TW          = `CS_TMR_W;
  localparam int PULSE_TICKS = `CS_PULSE_US / `CS_TICK_US;

  function automatic logic enters(st_t cur, st_t nxt, st_t s);
    return (nxt == s) && (cur != s);
  endfunction : enters

  logic [`CS_NPIN-1:0] meta;
  logic [`CS_NPIN-1:0] sync;
  logic vbus_por, vbus_min, vbus_sleep, vbus_ovp, vbus_sag, bat_ovp;
  logic bat_low, bat_short, bat_rch, term_cur, therm, port_sel;

  st_t         st;
  st_t         next_st;
  logic        tick;
  logic        short_mode;
  logic        kick;
  logic        rst_pend;
  logic        en_stat;
  lim_code_t   lim;
  logic        cdis;
  logic        cdis_q;
  logic        spec;
  logic        status_read;
  fault_code_t fault_code;
  fault_code_t evt_code;
  logic        evt_any;
  logic        batdet_armed;
  logic        short_q;
  logic [3:0]  cond_q;
  logic [3:0]  cond;
  logic [7:0]  rd_val;

  logic long_run, long_exp, short_run, short_exp, src_exp;
  logic batdet_run, batdet_exp, det_exp, retry_exp, pulse_run;
  logic src_run, det_run, retry_run;
  logic charging, sleep_c, cond_any, new_cycle, no_bat, restore;
  logic wr_ctrl, wr_ilim, rd_ctrl, rd_spec, enter_chg;
  logic long_start, short_start, retry_start, batdet_start;

  // Pin comparators cross into the clock domain
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {i_vbus_por, i_vbus_min, i_vbus_sleep, i_vbus_ovp, i_vbus_sag, i_bat_ovp,
               i_bat_low, i_bat_short, i_bat_rch, i_term_cur, i_therm_shdn, i_port_sel};
      sync <= meta;
    end
  end

  assign {vbus_por, vbus_min, vbus_sleep, vbus_ovp, vbus_sag, bat_ovp,
          bat_low, bat_short, bat_rch, term_cur, therm, port_sel} = sync;

  assign wr_ctrl  = i_reg_wr && (i_reg_addr == `CS_REG_CTRL);
  assign wr_ilim  = i_reg_wr && (i_reg_addr == `CS_REG_ILIM);
  assign rd_ctrl  = i_reg_rd && (i_reg_addr == `CS_REG_CTRL);
  assign rd_spec  = i_reg_rd && (i_reg_addr == `CS_REG_SPEC);
  assign charging = (st == ST_CHARGE);
  assign sleep_c  = vbus_sleep && vbus_min;
  assign cond     = {therm, vbus_ovp, bat_ovp, sleep_c};
  assign cond_any = |cond;
  assign new_cycle = (cdis_q && !cdis) || rst_pend;
  assign no_bat   = (batdet_run && bat_rch) || (batdet_armed && bat_short && bat_ovp);

  tick_divider #(
    .DIV (`CS_TICK_CYC)
  ) u_tick (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  );

  always_comb begin
    next_st = st;
    unique case (st)
      ST_NOSRC:      if (vbus_por) next_st = ST_SRC_TEST;
      ST_SRC_TEST: begin
        if (!vbus_min) next_st = ST_SRC_RETRY;
        else if (src_exp) next_st = (bat_low || short_mode) ? ST_CHARGE : ST_HIZ;
      end
      ST_SRC_RETRY:  if (retry_exp) next_st = ST_SRC_TEST;
      ST_READY:      if (new_cycle && !cdis) next_st = ST_CHARGE;
      ST_CHARGE: begin
        if (long_exp) next_st = ST_TFAULT;
        else if (no_bat) next_st = ST_HIZ;
        else if (short_mode && term_cur && bat_rch) next_st = ST_DETECT;
      end
      ST_DETECT:     if (det_exp) next_st = bat_rch ? ST_DONE : ST_RETRY_WAIT;
      ST_RETRY_WAIT: if (retry_exp) next_st = ST_CHARGE;
      ST_DONE:       if (!bat_rch || new_cycle) next_st = ST_CHARGE;
      ST_HIZ:        if (new_cycle && !cdis) next_st = ST_CHARGE;
      ST_TFAULT:     next_st = ST_TFAULT;
    endcase
    if (cdis && (st == ST_CHARGE || st == ST_DETECT || st == ST_RETRY_WAIT ||
                 st == ST_DONE)) begin
      next_st = ST_READY;
    end
    if (!vbus_por && st != ST_NOSRC && st != ST_TFAULT) begin
      next_st = ST_NOSRC;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= ST_NOSRC;
    end else begin
      st <= next_st;
    end
  end

  assign enter_chg    = enters(st, next_st, ST_CHARGE);
  assign long_start   = (enter_chg && !short_mode) || short_exp;
  assign short_start  = (i_reg_wr && !short_mode) || kick;
  assign retry_start  = enters(st, next_st, ST_SRC_RETRY) ||
                        enters(st, next_st, ST_RETRY_WAIT);
  assign batdet_start = batdet_armed && charging && short_q && !bat_short;
  assign restore      = short_exp || rst_pend ||
                        (st == ST_DETECT && det_exp && !bat_rch);

  interval_timer #(.W(TW)) u_long (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (long_start), .i_stop (i_reg_wr || next_st != ST_CHARGE),
    .i_hold (therm), .i_limit (TW'(P_LONG_TICKS)),
    .o_run (long_run), .o_expired (long_exp)
  );

  interval_timer #(.W(TW)) u_short (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (short_start), .i_stop (1'b0),
    .i_hold (therm), .i_limit (TW'(P_SHORT_TICKS)),
    .o_run (short_run), .o_expired (short_exp)
  );

  interval_timer #(.W(TW)) u_src (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (enters(st, next_st, ST_SRC_TEST)), .i_stop (st != ST_SRC_TEST),
    .i_hold (therm), .i_limit (TW'(P_SRC_TICKS)),
    .o_run (src_run), .o_expired (src_exp)
  );

  interval_timer #(.W(TW)) u_batdet (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (batdet_start), .i_stop (!batdet_armed),
    .i_hold (therm), .i_limit (TW'(P_BATDET_TICKS)),
    .o_run (batdet_run), .o_expired (batdet_exp)
  );

  interval_timer #(.W(TW)) u_detect (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (enters(st, next_st, ST_DETECT)), .i_stop (st != ST_DETECT),
    .i_hold (therm), .i_limit (TW'(P_DETECT_TICKS)),
    .o_run (det_run), .o_expired (det_exp)
  );

  interval_timer #(.W(TW)) u_retry (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (retry_start), .i_stop (1'b0),
    .i_hold (therm), .i_limit (TW'(P_RETRY_TICKS)),
    .o_run (retry_run), .o_expired (retry_exp)
  );

  interval_timer #(.W(TW)) u_pulse (
    .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_tick (tick),
    .i_start (evt_any), .i_stop (1'b0),
    .i_hold (1'b0), .i_limit (TW'(PULSE_TICKS)),
    .o_run (pulse_run), .o_expired ()
  );

  // Host-kicked mode and the self-clearing command bits
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      short_mode <= 1'b0;
      kick       <= 1'b0;
    end else begin
      if (i_reg_wr) short_mode <= 1'b1;
      else if (short_exp) short_mode <= 1'b0;
      kick <= wr_ctrl && i_reg_wdata[`CS_KICK_BIT];
    end
  end

  // Control values; restore puts back the defaults
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      en_stat  <= `CS_STATEN_DEF;
      lim      <= `CS_LIM_DEF;
      cdis     <= 1'b0;
      rst_pend <= 1'b0;
      cdis_q   <= 1'b0;
    end else begin
      cdis_q <= cdis;
      if (restore) begin
        en_stat  <= `CS_STATEN_DEF;
        lim      <= `CS_LIM_DEF;
        cdis     <= 1'b0;
        rst_pend <= 1'b0;
      end else begin
        if (wr_ctrl) en_stat <= i_reg_wdata[`CS_STATEN_BIT];
        if (wr_ilim) begin
          lim      <= i_reg_wdata[`CS_LIM_HI:`CS_LIM_LO];
          cdis     <= i_reg_wdata[`CS_CDIS_BIT];
          rst_pend <= i_reg_wdata[`CS_RST_BIT];
        end
      end
    end
  end

  // Power-up battery detect window
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      batdet_armed <= 1'b0;
      short_q      <= 1'b0;
    end else begin
      short_q <= bat_short;
      if (st == ST_SRC_TEST && enter_chg) batdet_armed <= P_HAS_BATDET && !short_mode;
      else if (batdet_exp || short_mode || !charging) batdet_armed <= 1'b0;
    end
  end

  // Fault event selection
  always_comb begin
    evt_any  = 1'b1;
    evt_code = `CS_FLT_NONE;
    if (charging && long_exp) evt_code = `CS_FLT_TIMER;
    else if (charging && no_bat) evt_code = `CS_FLT_NOBAT;
    else if (st == ST_SRC_TEST && !vbus_min) evt_code = `CS_FLT_BADSRC;
    else if (cond[3] && !cond_q[3]) evt_code = `CS_FLT_THERM;
    else if (cond[2] && !cond_q[2]) evt_code = `CS_FLT_INOVP;
    else if (cond[1] && !cond_q[1]) evt_code = `CS_FLT_BATOVP;
    else if (cond[0] && !cond_q[0]) evt_code = `CS_FLT_SLEEP;
    else if (!vbus_por && st != ST_NOSRC && st != ST_TFAULT) evt_code = `CS_FLT_SLEEP;
    else evt_any = 1'b0;
  end

  // Fault status: updates wait for a read, timer fault holds until reset
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_code  <= `CS_FLT_NONE;
      status_read <= 1'b1;
      cond_q      <= '0;
    end else begin
      cond_q <= cond;
      if (evt_code == `CS_FLT_TIMER ||
          (evt_any && (status_read || fault_code == `CS_FLT_NONE) &&
           fault_code != `CS_FLT_TIMER)) begin
        fault_code  <= evt_code;
        status_read <= 1'b0;
      end else if (rd_ctrl) begin
        status_read <= 1'b1;
      end else if (status_read && !cond_any && fault_code != `CS_FLT_TIMER &&
                   (charging || st == ST_DONE)) begin
        fault_code <= `CS_FLT_NONE;
      end
    end
  end

  // Special-source flag, set wins over clear on read
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spec <= 1'b0;
    end else if (charging && vbus_sag) begin
      spec <= 1'b1;
    end else if (rd_spec) begin
      spec <= 1'b0;
    end
  end

  always_comb begin
    rd_val = '0;
    unique case (i_reg_addr)
      `CS_REG_CTRL: begin
        rd_val[`CS_KICK_BIT]   = kick;
        rd_val[`CS_STATEN_BIT] = en_stat;
        rd_val[`CS_FAULT_HI:`CS_FAULT_LO] = fault_code;
        if (st == ST_TFAULT || fault_code != `CS_FLT_NONE)
          rd_val[`CS_STATE_HI:`CS_STATE_LO] = `CS_STS_FAULT;
        else if (st == ST_DONE) rd_val[`CS_STATE_HI:`CS_STATE_LO] = `CS_STS_DONE;
        else if (charging) rd_val[`CS_STATE_HI:`CS_STATE_LO] = `CS_STS_CHG;
        else rd_val[`CS_STATE_HI:`CS_STATE_LO] = `CS_STS_READY;
      end
      `CS_REG_ILIM: begin
        rd_val[`CS_RST_BIT]         = rst_pend;
        rd_val[`CS_LIM_HI:`CS_LIM_LO] = lim;
        rd_val[`CS_CDIS_BIT]        = cdis;
      end
      `CS_REG_SPEC: rd_val[`CS_SPEC_BIT] = spec;
      default: rd_val = '0;
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata    <= '0;
      o_ilim_code    <= `CS_LIM_100;
      o_conv_en      <= 1'b0;
      o_rev_sw_en    <= 1'b0;
      o_test_sink    <= 1'b0;
      o_detect_sink  <= 1'b0;
      o_short_chg    <= 1'b0;
      o_cur_reduce   <= 1'b0;
      o_hiz          <= 1'b0;
      o_use_defaults <= 1'b1;
      o_stat_out     <= 1'b0;
      o_stat_oe      <= 1'b0;
    end else begin
      if (i_reg_rd) o_reg_rdata <= rd_val;
      if (short_mode) o_ilim_code <= lim;
      else if (!P_HAS_PORT_SEL || port_sel) o_ilim_code <= `CS_LIM_500;
      else o_ilim_code <= `CS_LIM_100;
      o_conv_en      <= charging && !cond_any;
      o_rev_sw_en    <= !sleep_c && (charging || st == ST_DETECT ||
                        st == ST_DONE || st == ST_RETRY_WAIT);
      o_test_sink    <= (st == ST_SRC_TEST);
      o_detect_sink  <= (st == ST_DETECT);
      o_short_chg    <= charging && bat_short;
      o_cur_reduce   <= charging && vbus_sag;
      o_hiz          <= (st == ST_HIZ);
      o_use_defaults <= !short_mode;
      o_stat_out     <= 1'b0;
      o_stat_oe      <= pulse_run || (charging && en_stat);
    end
  end
endmodule : charge_safety_supervisor
`default_nettype wire

// *** design/chg_sup_cfg.svh ***
// Constants for the charge safety supervisor
`ifndef CHG_SUP_CFG_SVH
`define CHG_SUP_CFG_SVH

`define CS_CLK_HZ      25000000
`define CS_US_PER_S    1000000
`define CS_US_PER_MS   1000
`define CS_S_PER_MIN   60
`define CS_TICK_US     1
`define CS_TICK_CYC    (`CS_CLK_HZ / `CS_US_PER_S * `CS_TICK_US)
`define CS_TMR_W       30
`define CS_NPIN        12

`define CS_LONG_MIN    15
`define CS_SHORT_S     32
`define CS_PULSE_US    128
`define CS_SRC_MS      30
`define CS_BATDET_MS   32
`define CS_DETECT_MS   32
`define CS_RETRY_MS    500

`define CS_REG_CTRL    8'h00
`define CS_REG_ILIM    8'h01
`define CS_REG_SPEC    8'h05

`define CS_KICK_BIT    7
`define CS_STATEN_BIT  6
`define CS_STATE_HI    5
`define CS_STATE_LO    4
`define CS_FAULT_HI    2
`define CS_FAULT_LO    0
`define CS_RST_BIT     7
`define CS_LIM_HI      5
`define CS_LIM_LO      4
`define CS_CDIS_BIT    2
`define CS_SPEC_BIT    4

`define CS_STATEN_DEF  1'b1
`define CS_LIM_DEF     2'h0
`define CS_LIM_100     2'h0
`define CS_LIM_500     2'h1

`define CS_STS_READY   2'h0
`define CS_STS_CHG     2'h1
`define CS_STS_DONE    2'h2
`define CS_STS_FAULT   2'h3

`define CS_FLT_NONE    3'h0
`define CS_FLT_INOVP   3'h1
`define CS_FLT_SLEEP   3'h2
`define CS_FLT_BADSRC  3'h3
`define CS_FLT_BATOVP  3'h4
`define CS_FLT_THERM   3'h5
`define CS_FLT_TIMER   3'h6
`define CS_FLT_NOBAT   3'h7

`endif

// *** design/chg_sup_pkg.sv ***
// Types for the charge safety supervisor
`default_nettype none
package chg_sup_pkg;
  typedef logic [1:0] lim_code_t;
  typedef logic [2:0] fault_code_t;
  typedef enum logic [3:0] {
    ST_NOSRC, ST_SRC_TEST, ST_SRC_RETRY, ST_READY, ST_CHARGE,
    ST_DETECT, ST_RETRY_WAIT, ST_DONE, ST_HIZ, ST_TFAULT
  } st_t;
endpackage : chg_sup_pkg
`default_nettype wire

// *** design/interval_timer.sv ***
// Restartable tick counter with freeze and expiry pulse
`default_nettype none
module interval_timer #(
  parameter int W = 30
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_tick,
  input  wire logic         i_start,
  input  wire logic         i_stop,
  input  wire logic         i_hold,
  input  wire logic [W-1:0] i_limit,
  output logic              o_run,
  output logic              o_expired
);
  logic [W-1:0] cnt;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt       <= '0;
      o_run     <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_start) begin
        cnt   <= '0;
        o_run <= 1'b1;
      end else if (i_stop) begin
        o_run <= 1'b0;
      end else if (o_run && i_tick && !i_hold) begin
        if (cnt == i_limit - 1'b1) begin
          o_run     <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : interval_timer
`default_nettype wire

// *** design/tick_divider.sv ***
// Fixed-rate tick enable from the main clock
`default_nettype none
module tick_divider #(
  parameter int DIV = 25
) (
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  output logic      o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : tick_divider
`default_nettype wire

// *** verification/css_asserts.sv ***
// Port checker for the charge safety supervisor
`default_nettype none
module css_asserts #(
  parameter bit P_HAS_PORT_SEL = 1'b1
) (
  input wire logic                  i_mclk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_vbus_min,
  input wire logic                  i_vbus_sleep,
  input wire logic                  i_vbus_ovp,
  input wire logic                  i_vbus_sag,
  input wire logic                  i_bat_ovp,
  input wire logic                  i_bat_short,
  input wire logic                  i_therm_shdn,
  input wire logic                  i_port_sel,
  input wire chg_sup_pkg::lim_code_t o_ilim_code,
  input wire logic                  o_conv_en,
  input wire logic                  o_rev_sw_en,
  input wire logic                  o_test_sink,
  input wire logic                  o_detect_sink,
  input wire logic                  o_short_chg,
  input wire logic                  o_cur_reduce,
  input wire logic                  o_hiz,
  input wire logic                  o_use_defaults
);
  import chg_sup_pkg::*;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  sequence hot_held;
    i_therm_shdn [*6];
  endsequence
  sequence sleep_held;
    (i_vbus_sleep && i_vbus_min) [*6];
  endsequence
  sequence pin_held;
    (o_use_defaults && $stable(i_port_sel)) [*6];
  endsequence
  therm_stop_a: assert property (hot_held |-> !o_conv_en)
    else $error("converter on in thermal shutdown");
  sleep_off_a: assert property (sleep_held |-> !o_conv_en && !o_rev_sw_en)
    else $error("switches on in sleep");
  in_ovp_a: assert property (i_vbus_ovp [*6] |-> !o_conv_en)
    else $error("converter on in input over-voltage");
  bat_ovp_a: assert property (i_bat_ovp [*6] |-> !o_conv_en)
    else $error("converter on in battery over-voltage");
  port_limit_a: assert property (pin_held |->
    o_ilim_code == ((!P_HAS_PORT_SEL || i_port_sel) ? 2'h1 : 2'h0))
    else $error("input limit does not follow the select pin");
  sink_excl_a: assert property (o_test_sink || o_detect_sink |-> !o_conv_en)
    else $error("sink applied with converter on");
  hiz_off_a: assert property (o_hiz |-> !o_conv_en)
    else $error("converter on in high impedance");
  sag_cut_a: assert property ((i_vbus_sag && o_conv_en) [*6] |-> o_cur_reduce)
    else $error("no current reduction on input sag");
  short_mode_a: assert property ((i_bat_short && o_conv_en) [*6] |-> o_short_chg)
    else $error("no short-circuit mode on low battery");
endmodule : css_asserts
bind charge_safety_supervisor css_asserts #(.P_HAS_PORT_SEL(P_HAS_PORT_SEL)) u_chk (
  .i_mclk, .i_sys_rst, .i_vbus_min, .i_vbus_sleep, .i_vbus_ovp, .i_vbus_sag,
  .i_bat_ovp, .i_bat_short, .i_therm_shdn, .i_port_sel, .o_ilim_code, .o_conv_en,
  .o_rev_sw_en, .o_test_sink, .o_detect_sink, .o_short_chg, .o_cur_reduce, .o_hiz,
  .o_use_defaults
);
`default_nettype wire

// *** verification/host_model.sv ***
// Host processor model on the register port
`default_nettype none
module host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // Kick and control writes; idle lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_mclk);
    o_rd = 1'b0;
    o_addr = ~a;
    @(negedge i_mclk);
    d = i_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Bench for the charge safety supervisor
`default_nettype none
module tb_top;
  import chg_sup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 25;
  logic       i_mclk, i_sys_rst, i_vbus_por, i_vbus_min, i_vbus_sag;
  logic       i_bat_low, i_bat_short, i_port_sel, i_reg_wr, i_reg_rd;
  logic       i_bat_rch, i_term_cur;
  logic [3:0] flt;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  lim_code_t  o_ilim_code;
  logic       o_conv_en, o_rev_sw_en, o_test_sink, o_short_chg, o_cur_reduce;
  logic       o_hiz, o_use_defaults, o_stat_out, o_stat_oe, stat_pin;
  logic [7:0] code [4] = '{8'h01, 8'h04, 8'h05, 8'h02};
  int         errors = 0;
  int         checks = 0;
  int         n;
  assign stat_pin = o_stat_oe ? o_stat_out : 1'b1;
  charge_safety_supervisor #(.P_LONG_TICKS(1000), .P_SHORT_TICKS(500), .P_SRC_TICKS(30),
    .P_BATDET_TICKS(32), .P_RETRY_TICKS(50)) DUT (
    .i_mclk, .i_sys_rst, .i_vbus_por, .i_vbus_min, .i_vbus_sleep(flt[3]),
    .i_vbus_ovp(flt[0]), .i_vbus_sag, .i_bat_ovp(flt[1]), .i_bat_low, .i_bat_short,
    .i_bat_rch, .i_term_cur, .i_therm_shdn(flt[2]), .i_port_sel,
    .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_ilim_code,
    .o_conv_en, .o_rev_sw_en, .o_test_sink, .o_detect_sink(), .o_short_chg,
    .o_cur_reduce, .o_hiz, .o_use_defaults, .o_stat_out, .o_stat_oe);
  host_model host (.i_mclk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
    .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic in_rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      errors++;
      $display("wrong value at %0t: count %0d not in %0d..%0d", $time, v, lo, hi);
    end
  endtask : in_rng
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    host.rd(a, d);
    cmp(d & m, e);
  endtask : rd_chk
  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
    in_rng(n, 0, lim - 1);
  endtask : wait_on
  task automatic t_reset;
    rd_chk(8'h00, 8'h40, 8'hff);
    rd_chk(8'h01, 8'h00, 8'hff);
    rd_chk(8'h05, 8'h00, 8'hff);
    cmp(o_use_defaults, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_badsrc;
    i_vbus_min = 1'b1;
    i_vbus_por = 1'b1;
    wait_on(o_test_sink, 1'b1, 10);
    repeat (10 * TK) @(negedge i_mclk);
    i_vbus_min = 1'b0;
    wait_on(o_stat_oe, 1'b1, 10);
    cmp(o_test_sink, 1'b0);
    rd_chk(8'h00, 8'h03, 8'h07);
    i_vbus_min = 1'b1;
    wait_on(o_conv_en, 1'b1, 90 * TK);
    cmp(o_ilim_code, 2'h0);
    i_port_sel = 1'b1;
    repeat (6) @(negedge i_mclk);
    cmp(o_ilim_code, 2'h1);
    $display("source test done");
  endtask : t_badsrc
  task automatic t_short;
    repeat (130 * TK) @(negedge i_mclk);
    cmp(stat_pin, 1'b0);
    host.wr(8'h00, 8'h80);
    repeat (4) @(negedge i_mclk);
    cmp(o_use_defaults, 1'b0);
    cmp(stat_pin, 1'b1);
    rd_chk(8'h00, 8'h10, 8'hff);
    repeat (400 * TK) @(negedge i_mclk);
    host.wr(8'h00, 8'h80);
    repeat (400 * TK) @(negedge i_mclk);
    cmp(o_use_defaults, 1'b0);
    wait_on(o_use_defaults, 1'b1, 150 * TK);
    rd_chk(8'h00, 8'h40, 8'h40);
    wait_on(o_conv_en, 1'b1, 100 * TK);
    $display("short timer test done");
  endtask : t_short
  task automatic t_long;
    wait_on(o_conv_en, 1'b0, 1100 * TK);
    n = 0;
    repeat (140 * TK) begin
      @(negedge i_mclk);
      if (stat_pin === 1'b0) n++;
    end
    in_rng(n, 127 * TK - 2, 128 * TK + 4);
    rd_chk(8'h00, 8'h76, 8'hff);
    host.wr(8'h09, 8'h00);
    repeat (50 * TK) @(negedge i_mclk);
    cmp(o_conv_en, 1'b0);
    rd_chk(8'h00, 8'h36, 8'h37);
    i_sys_rst = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    rd_chk(8'h00, 8'h40, 8'hff);
    $display("long timer test done");
  endtask : t_long
  task automatic t_faults;
    wait_on(o_conv_en, 1'b1, 60 * TK);
    i_bat_short = 1'b1;
    repeat (6) @(negedge i_mclk);
    cmp(o_short_chg, 1'b1);
    i_bat_short = 1'b0;
    i_vbus_sag = 1'b1;
    repeat (6) @(negedge i_mclk);
    cmp(o_cur_reduce, 1'b1);
    i_vbus_sag = 1'b0;
    repeat (3) @(negedge i_mclk);
    rd_chk(8'h05, 8'h10, 8'h10);
    rd_chk(8'h05, 8'h00, 8'h10);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h00, 8'h80);
      wait_on(stat_pin, 1'b1, 130 * TK);
      flt[k] = 1'b1;
      repeat (10) @(negedge i_mclk);
      cmp(o_conv_en, 1'b0);
      cmp(stat_pin, 1'b0);
      if (k == 3) cmp(o_rev_sw_en, 1'b0);
      rd_chk(8'h00, code[k], 8'h07);
      flt[k] = 1'b0;
      wait_on(o_conv_en, 1'b1, 100 * TK);
    end
    $display("fault test done");
  endtask : t_faults
  task automatic t_hiz;
    i_vbus_por = 1'b0;
    repeat (10 * TK) @(negedge i_mclk);
    i_bat_low = 1'b0;
    i_sys_rst = 1'b1;
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    i_vbus_por = 1'b1;
    wait_on(o_hiz, 1'b1, 60 * TK);
    cmp(o_conv_en, 1'b0);
    $display("high impedance test done");
  endtask : t_hiz
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    #(90000 * 40);
    errors++;
    tally_and_finish();
  end
  initial begin
    i_sys_rst = 1'b1;
    {i_vbus_por, i_vbus_min, i_vbus_sag, i_bat_short, i_port_sel, i_bat_rch, i_term_cur} = 7'h00;
    i_bat_low = 1'b1;
    flt = 4'h0;
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    t_badsrc();
    t_short();
    t_long();
    t_faults();
    t_hiz();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
